// ### pkg/dpt_pkg.sv
// package: register map, field layout and reset values for the channel pointer tracker
package dpt_pkg;
  localparam int          DPT_DATA_W        = 32;
  localparam int          DPT_FIELD_W       = 16;
  localparam int          DPT_ADDR_W        = 8;
  localparam int          DPT_XFER_W        = 3;
  localparam logic [7:0]  DPT_SRC_IDX_OFF   = 8'h00;
  localparam logic [7:0]  DPT_DST_IDX_OFF   = 8'h04;
  localparam logic [7:0]  DPT_EVT_SIZE_OFF  = 8'h08;
  localparam logic [7:0]  DPT_EVT_PROG_OFF  = 8'h0c;
  localparam logic [7:0]  DPT_SRC_LEN_OFF   = 8'h10;
  localparam logic [7:0]  DPT_DST_LEN_OFF   = 8'h14;
  localparam logic [7:0]  DPT_MATCH_OFF     = 8'h18;
  localparam logic [7:0]  DPT_CTRL_OFF      = 8'h1c;
  localparam int          DPT_CTRL_PAT_BIT  = 0;
  localparam logic [15:0] DPT_FIELD_RST     = 16'h0000;
  localparam logic [7:0]  DPT_MATCH_RST     = 8'h00;
  localparam logic [16:0] DPT_ZERO_AS_FULL  = 17'h10000;
endpackage

// ### hw/dpt_wrap_counter.sv
// wrapping byte counter: advance by a transfer, clear on request, wrap at a length
`timescale 1ns/100ps
module dpt_wrap_counter
  import dpt_pkg::*;
#(
  parameter int W  = 16,
  parameter int XW = 3
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          clear_i,
  input  wire logic          adv_i,
  input  wire logic [XW-1:0] step_i,
  input  wire logic [W-1:0]  length_i,
  output logic      [W-1:0]  count_o,
  output logic               wrap_o
);
  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  wire  [W:0]   limit = (length_i == '0) ? DPT_ZERO_AS_FULL[W:0] : {1'b0, length_i};
  wire  [W:0]   sum   = {1'b0, count_q} + {{(W+1-XW){1'b0}}, step_i};
  assign wrap_o = adv_i && (sum >= limit);
  always_comb begin
    count_d = count_q;
    if (clear_i) begin
      count_d = '0;
    end else if (adv_i) begin
      count_d = wrap_o ? '0 : sum[W-1:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end
  assign count_o = count_q;
endmodule

// ### hw/dpt_channel.sv
// dma channel pointer tracking with apb register slave
`timescale 1ns/100ps
//
// Summary of operation
// R1 - a 16-bit read-only source byte index tells which source byte is accessed next.
// R2 - in pattern termination mode a pattern match clears the source index.
// R3 - a 16-bit read-only destination byte index tells which destination byte is next.
// R4 - software writes a 16-bit cell size, bytes per trigger event, where zero means 65,536.
// R5 - a 16-bit read-only cell progress counter counts bytes moved since the last event.
// R6 - in pattern termination mode a pattern match also clears the cell progress counter.
// R7 - bits 31 to 16 of the index, size and progress registers read as zero.
// R8 - after reset the index, size and progress fields are all zero.
// R9 - source and destination buffer lengths are 16-bit byte counts where zero means 65,536.
// R10 - software loads the byte to match into the match byte field for pattern termination.
// R11 - each transfer advances indices and progress; indices wrap at their length, progress clears per event.
//
module dpt_channel
  import dpt_pkg::*;
#(
  parameter int FW = DPT_FIELD_W,
  parameter int XW = DPT_XFER_W
) (
  input  wire logic                  CLK_SYS_I,
  input  wire logic                  RESETN_I,
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [DPT_ADDR_W-1:0] PADDR_I,
  input  wire logic [DPT_DATA_W-1:0] PWDATA_I,
  input  wire logic [3:0]            PSTRB_I,
  input  wire logic                  EVENT_I,
  input  wire logic                  XFER_I,
  input  wire logic [XW-1:0]         XFER_BYTES_I,
  input  wire logic                  MATCH_I,
  output logic                       PREADY_O,
  output logic [DPT_DATA_W-1:0]      PRDATA_O,
  output logic                       PSLVERR_O,
  output logic                       CELL_DONE_O,
  output logic                       SRC_WRAP_O,
  output logic                       DST_WRAP_O,
  output logic [7:0]                 MATCH_BYTE_O,
  output logic                       PAT_MODE_O
);
  ////////////////////////////////////////////////////////////////////////
  // apb decode
  logic [FW-1:0]          evt_size_q;
  logic [FW-1:0]          src_len_q;
  logic [FW-1:0]          dst_len_q;
  logic [7:0]             match_q;
  logic                   pat_mode_q;
  logic                   pready_q;
  logic [DPT_DATA_W-1:0]  prdata_q;
  logic                   pslverr_q;
  logic                   cell_done_q;
  logic                   src_wrap_q;
  logic                   dst_wrap_q;
  logic [FW-1:0]          src_idx;
  logic [FW-1:0]          dst_idx;
  logic [FW-1:0]          prog;
  logic                   src_wrap;
  logic                   dst_wrap;
  logic                   prog_full;

  wire access   = PSEL_I && PENABLE_I && !pready_q;
  // write lands on the edge that completes the transfer
  wire wr_acc   = PSEL_I && PENABLE_I && pready_q && PWRITE_I;
  wire sel_src  = (PADDR_I == DPT_SRC_IDX_OFF);
  wire sel_dst  = (PADDR_I == DPT_DST_IDX_OFF);
  wire sel_size = (PADDR_I == DPT_EVT_SIZE_OFF);
  wire sel_prog = (PADDR_I == DPT_EVT_PROG_OFF);
  wire sel_slen = (PADDR_I == DPT_SRC_LEN_OFF);
  wire sel_dlen = (PADDR_I == DPT_DST_LEN_OFF);
  wire sel_mat  = (PADDR_I == DPT_MATCH_OFF);
  wire sel_ctl  = (PADDR_I == DPT_CTRL_OFF);
  wire mapped   = sel_src | sel_dst | sel_size | sel_prog | sel_slen | sel_dlen | sel_mat | sel_ctl;
  wire ro_hit   = sel_src | sel_dst | sel_prog;
  wire bad      = !mapped || (PWRITE_I && ro_hit);
  wire pat_clr  = pat_mode_q && MATCH_I; // [R2] [R6]

  // read mux, upper half always zero
  wire [FW-1:0] rd_field = sel_src  ? src_idx : // [R1]
                           sel_dst  ? dst_idx : // [R3]
                           sel_size ? evt_size_q :
                           sel_prog ? prog : // [R5]
                           sel_slen ? src_len_q :
                           sel_dlen ? dst_len_q :
                           sel_mat  ? {{(FW-8){1'b0}}, match_q} :
                           sel_ctl  ? {{(FW-1){1'b0}}, pat_mode_q} : '0;
  wire [DPT_DATA_W-1:0] rd_word = {{(DPT_DATA_W-FW){1'b0}}, rd_field}; // [R7]

  // byte-lane merge for 16-bit fields
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // software registers
  wire          wr_ok      = wr_acc && !bad;
  wire          size_we    = wr_ok && sel_size;
  wire          slen_we    = wr_ok && sel_slen;
  wire          dlen_we    = wr_ok && sel_dlen;
  wire          match_we   = wr_ok && sel_mat && PSTRB_I[0];
  wire          mode_we    = wr_ok && sel_ctl && PSTRB_I[0];
  wire [FW-1:0] evt_size_d = merge16(evt_size_q, PWDATA_I, PSTRB_I);
  wire [FW-1:0] src_len_d  = merge16(src_len_q, PWDATA_I, PSTRB_I);
  wire [FW-1:0] dst_len_d  = merge16(dst_len_q, PWDATA_I, PSTRB_I);
  wire [7:0]    match_d    = PWDATA_I[7:0];
  wire          pat_mode_d = PWDATA_I[DPT_CTRL_PAT_BIT];

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      evt_size_q <= DPT_FIELD_RST; // [R8]
    end else if (size_we) begin
      evt_size_q <= evt_size_d; // [R4]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      src_len_q <= DPT_FIELD_RST;
    end else if (slen_we) begin
      src_len_q <= src_len_d; // [R9]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      dst_len_q <= DPT_FIELD_RST;
    end else if (dlen_we) begin
      dst_len_q <= dst_len_d; // [R9]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      match_q <= DPT_MATCH_RST;
    end else if (match_we) begin
      match_q <= match_d; // [R10]
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      pat_mode_q <= 1'b0;
    end else if (mode_we) begin
      pat_mode_q <= pat_mode_d; // [R2]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb response, one wait state
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && bad;
      prdata_q  <= (access && !PWRITE_I && mapped) ? rd_word : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pointer counters
  dpt_wrap_counter #(.W(FW), .XW(XW)) u_src (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RESETN_I),
    .clear_i  (pat_clr), // [R2]
    .adv_i    (XFER_I), // [R11]
    .step_i   (XFER_BYTES_I),
    .length_i (src_len_q), // [R9]
    .count_o  (src_idx),
    .wrap_o   (src_wrap)
  );
  dpt_wrap_counter #(.W(FW), .XW(XW)) u_dst (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RESETN_I),
    .clear_i  (1'b0),
    .adv_i    (XFER_I), // [R11]
    .step_i   (XFER_BYTES_I),
    .length_i (dst_len_q), // [R9]
    .count_o  (dst_idx),
    .wrap_o   (dst_wrap)
  );
  // progress counter clears on new event or on a match in pattern mode; wraps when the cell is full
  dpt_wrap_counter #(.W(FW), .XW(XW)) u_prog (
    .clk_i    (CLK_SYS_I),
    .rst_n_i  (RESETN_I),
    .clear_i  (pat_clr || EVENT_I), // [R6] [R11]
    .adv_i    (XFER_I),
    .step_i   (XFER_BYTES_I),
    .length_i (evt_size_q), // [R4]
    .count_o  (prog),
    .wrap_o   (prog_full)
  );

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESETN_I) begin
      cell_done_q <= 1'b0;
      src_wrap_q  <= 1'b0;
      dst_wrap_q  <= 1'b0;
    end else begin
      cell_done_q <= prog_full && !pat_clr && !EVENT_I;
      src_wrap_q  <= src_wrap && !pat_clr;
      dst_wrap_q  <= dst_wrap;
    end
  end

  assign PREADY_O     = pready_q;
  assign PRDATA_O     = prdata_q;
  assign PSLVERR_O    = pslverr_q;
  assign CELL_DONE_O  = cell_done_q;
  assign SRC_WRAP_O   = src_wrap_q;
  assign DST_WRAP_O   = dst_wrap_q;
  assign MATCH_BYTE_O = match_q;
  assign PAT_MODE_O   = pat_mode_q;
endmodule

// ### verification/dpt_channel_sva.sv
// port checker for the channel pointer tracker
`timescale 1ns/100ps
module dpt_channel_sva
  import dpt_pkg::*;
(
  input wire logic                  CLK_SYS_I,
  input wire logic                  RESETN_I,
  input wire logic                  PSEL_I,
  input wire logic                  PENABLE_I,
  input wire logic                  PWRITE_I,
  input wire logic [DPT_ADDR_W-1:0] PADDR_I,
  input wire logic                  XFER_I,
  input wire logic                  PREADY_O,
  input wire logic [DPT_DATA_W-1:0] PRDATA_O,
  input wire logic                  PSLVERR_O,
  input wire logic                  CELL_DONE_O,
  input wire logic                  SRC_WRAP_O,
  input wire logic                  PAT_MODE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);
  wire wr = PSEL_I & PENABLE_I & ~PREADY_O & PWRITE_I;
  property p_src_ro; wr && PADDR_I == DPT_SRC_IDX_OFF |=> PSLVERR_O; endproperty
  a_src_ro: assert property (p_src_ro) else $error("src write kept");
  property p_dst_ro; wr && PADDR_I == DPT_DST_IDX_OFF |=> PSLVERR_O; endproperty
  a_dst_ro: assert property (p_dst_ro) else $error("dst write kept");
  property p_size_wr; wr && PADDR_I == DPT_EVT_SIZE_OFF |=> PREADY_O && !PSLVERR_O; endproperty
  a_size_wr: assert property (p_size_wr) else $error("size write bad");
  property p_prog_ro; wr && PADDR_I == DPT_EVT_PROG_OFF |=> PSLVERR_O; endproperty
  a_prog_ro: assert property (p_prog_ro) else $error("prog write kept");
  property p_upper; PREADY_O |-> PRDATA_O[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper bits set");
  property p_reset; disable iff (1'b0) !RESETN_I |=> !PREADY_O && !PAT_MODE_O && PRDATA_O == 32'h0; endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_wrap; SRC_WRAP_O |-> $past(XFER_I) || $past(XFER_I, 2); endproperty
  a_wrap: assert property (p_wrap) else $error("wrap no xfer");
  property p_cell; CELL_DONE_O |-> $past(XFER_I); endproperty
  a_cell: assert property (p_cell) else $error("done no xfer");
endmodule

// ### verification/dpt_xfer_src.sv
// far-side traffic source: transfer, event and match pulses
`timescale 1ns/100ps
module dpt_xfer_src (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] rnd_i,
  output logic             ev_o,
  output logic             xf_o,
  output logic [2:0]       nb_o,
  output logic             mt_o
);
  initial {ev_o, xf_o, nb_o, mt_o} = 6'h00;
  always @(posedge clk_i) begin
    xf_o <= go_i & rnd_i[0];
    nb_o <= 3'(rnd_i[2:1]) + 3'h1;
    ev_o <= go_i & (rnd_i[6:3] == 4'h0);
    mt_o <= go_i & (rnd_i[10:7] == 4'h0);
  end
endmodule

// ### verification/test_dma_channel_pointer_tracking.sv
// self-checking bench for the channel pointer tracker
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", n, e, s); end end
module test_dma_channel_pointer_tracking
  import dpt_pkg::*;
;
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, go = 0, ev, xf, mt, prdy, perr, pmode, er;
  logic        ews = 0, ewd = 0, ewc = 0, swrap, dwrap, cdone;
  logic [3:0]  pstb = 4'hf;
  logic [7:0]  padr = 0, mbyte;
  logic [2:0]  nb;
  logic [15:0] rnd = 0;
  logic [31:0] pwd = 0, prd, rd, st = 32'd56794;
  int          fails = 0, n_tests = 0, cyc = 0, ms = 0, md = 0, mp = 0, sl, dl, cs = 0, pat = 0;
  initial forever #25 clk = ~clk;
  dpt_channel u_dut (.CLK_SYS_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(padr), .PWDATA_I(pwd), .PSTRB_I(pstb), .EVENT_I(ev), .XFER_I(xf), .XFER_BYTES_I(nb),
    .MATCH_I(mt), .PREADY_O(prdy), .PRDATA_O(prd), .PSLVERR_O(perr), .CELL_DONE_O(cdone), .SRC_WRAP_O(swrap),
    .DST_WRAP_O(dwrap), .MATCH_BYTE_O(mbyte), .PAT_MODE_O(pmode));
  dpt_xfer_src u_src (.clk_i(clk), .go_i(go), .rnd_i(rnd), .ev_o(ev), .xf_o(xf), .nb_o(nb), .mt_o(mt));
  function logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  function int adv(int v, int n, int l);
    return (v + n >= (l == 0 ? 65536 : l)) ? 0 : v + n;
  endfunction
  always @(posedge clk) begin
    rnd <= 16'(xs());
    cyc++;
    if (cyc > 9000) begin
      fails++;
      stop_test();
    end
    if (rst_n) begin
      `CHK("src wrap", ews, swrap)
      `CHK("dst wrap", ewd, dwrap)
      `CHK("cell done", ewc, cdone)
    end
    ews = xf && adv(ms, nb, sl) == 0 && !(mt && pat[0]);
    ewd = xf && adv(md, nb, dl) == 0;
    ewc = xf && adv(mp, nb, cs) == 0 && !ev && !(mt && pat[0]);
    if (xf) begin
      ms = adv(ms, nb, sl);
      md = adv(md, nb, dl);
      mp = adv(mp, nb, cs);
    end
    if (mt && pat[0]) ms = 0;
    if (ev || (mt && pat[0])) mp = 0;
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task chk_all();
    int e[4];
    e = '{ms, md, cs, mp};
    for (int k = 0; k < 4; k++) begin
      apb(0, 8'(4 * k), 0);
      `CHK("count", 32'(e[k]), rd)
    end
  endtask
  task stop_test();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1;
    chk_all();
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'(4 * k), 32'hffff);
      `CHK("ro err", k != 2, er)
    end
    apb(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, rd)
    `CHK("unmapped err", 1'b1, er)
    apb(1, DPT_MATCH_OFF, 32'h5a);
    for (int i = 0; i < 6; i++) begin
      sl = i == 5 ? 0 : xs() % 48 + 1;
      dl = xs() % 48 + 1;
      cs = i == 4 ? 0 : xs() % 32 + 1;
      pat = i % 2;
      apb(1, DPT_SRC_LEN_OFF, 32'(sl));
      apb(1, DPT_DST_LEN_OFF, 32'(dl));
      apb(1, DPT_EVT_SIZE_OFF, 32'hffff0000 | 32'(cs));
      apb(1, DPT_CTRL_OFF, 32'(pat));
      go <= 1;
      repeat (150) @(posedge clk);
      go <= 0;
      repeat (4) @(posedge clk);
      chk_all();
      `CHK("mode", pat[0], pmode)
    end
    `CHK("match", 8'h5a, mbyte)
    pstb <= 4'h2;
    apb(1, DPT_EVT_SIZE_OFF, 32'h000037ff);
    pstb <= 4'hf;
    cs = cs | 32'h3700;
    apb(0, DPT_EVT_SIZE_OFF, 0);
    `CHK("strobe", 32'(cs), rd)
    stop_test();
  end
endmodule
bind dpt_channel dpt_channel_sva u_sva (.CLK_SYS_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I,
  .XFER_I, .PREADY_O, .PRDATA_O, .PSLVERR_O, .CELL_DONE_O, .SRC_WRAP_O, .PAT_MODE_O);
